// ===== dpsb_map.svh
// address map, field layout and reset values of the dual-port sequential buffer ports
`ifndef DPSB_MAP_SVH
`define DPSB_MAP_SVH
`define DPSB_ADDR_W 12
`define DPSB_DEPTH 4096
`define DPSB_CMD_WR_W 12
`define DPSB_CMD_RD_W 13
`define DPSB_PTR_RESET 12'h000
`define DPSB_END1_RESET 12'hfff
`define DPSB_END2_RESET 12'h000
`define DPSB_LO_MSB 7
`define DPSB_HI_LSB 8
`endif

// ===== dpsb_pkg.sv
// types shared by the dual-port sequential buffer ports
package dpsb_pkg;
   typedef struct packed {
      logic port_select_n;
      logic command_space_select_n;
      logic random_read_write;
      logic random_output_gate_n;
      logic low_byte_lane_n;
      logic high_byte_lane_n;
   } dpsb_rand_ctl_t;

   typedef struct packed {
      logic sequential_port_select_n;
      logic pointer_advance_enable_n;
      logic sequential_read_write;
      logic sequential_output_gate_n;
   } dpsb_seq_ctl_t;

   typedef enum logic [1:0] {
      DPSB_RND_IDLE,
      DPSB_RND_ARRAY,
      DPSB_RND_CMD
   } dpsb_rnd_mode_t;
endpackage

// ===== dpsb_ports.sv
// port control of the 4k x 16 dual-port sequential buffer
`include "dpsb_map.svh"

// Function
// - lower lane only drives lower byte
// - upper lane only drives upper byte
// - random write stores enabled byte lanes
// - deselect floats data, enters low power
// - output gate high floats read data
// - both lanes high float, stay powered
// - command write takes bits 0 to 11
// - command read returns bits 0 to 12
// - command access accepts either lane alone
// - random port ignores sequential signals
// - sequential select sampled on clock edge
// - advancing read outputs word; reaching end one sets flag1
// - reaching end two sets flag2 only
// - count disabled holds pointer and flags
// - output gate floats, pointer still advances
// - unchanged flag keeps previous value
// - reset clears control state asynchronously
module dpsb_ports #(
   parameter int ADDR_W = `DPSB_ADDR_W,
   parameter int DEPTH = `DPSB_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire dpsb_pkg::dpsb_rand_ctl_t random_ctl,
   input wire logic [ADDR_W-1:0] random_addr,
   input wire logic [15:0] random_data_in,
   output logic [15:0] random_data_out,
   output logic [1:0] random_data_oe,
   output logic random_low_power,
   input wire dpsb_pkg::dpsb_seq_ctl_t seq_ctl,
   output logic [15:0] seq_data_out,
   output logic seq_data_oe,
   output logic seq_low_power,
   output logic first_buffer_end_flag_n,
   output logic second_buffer_end_flag_n,
   output logic [ADDR_W-1:0] seq_pointer
);
   logic [15:0] mem [DEPTH];
   logic [`DPSB_CMD_RD_W-1:0] cmd_reg;
   logic [ADDR_W-1:0] end1_addr;
   logic [ADDR_W-1:0] end2_addr;
   logic seq_sel;
   logic seq_rd;
   logic seq_oe_n;
   logic [15:0] seq_word;

   // random side: purely combinational, no sequential term feeds it
   wire logic rnd_array = !random_ctl.port_select_n && random_ctl.command_space_select_n;
   wire logic rnd_cmd = random_ctl.port_select_n && !random_ctl.command_space_select_n;
   wire logic rnd_any = rnd_array || rnd_cmd;
   wire logic [1:0] lane_en = {!random_ctl.high_byte_lane_n, !random_ctl.low_byte_lane_n};
   wire logic rnd_read = rnd_any && random_ctl.random_read_write && !random_ctl.random_output_gate_n;
   wire logic rnd_write = rnd_any && !random_ctl.random_read_write;
   wire dpsb_pkg::dpsb_rnd_mode_t rnd_mode = rnd_array ? dpsb_pkg::DPSB_RND_ARRAY :
      (rnd_cmd ? dpsb_pkg::DPSB_RND_CMD : dpsb_pkg::DPSB_RND_IDLE);
   wire logic [15:0] cmd_word = {{(16-`DPSB_CMD_RD_W){1'b0}}, cmd_reg};
   wire logic [15:0] rnd_word = (rnd_mode == dpsb_pkg::DPSB_RND_CMD) ? cmd_word : mem[random_addr];

   assign random_data_out = rnd_word;
   assign random_data_oe = rnd_read ? lane_en : 2'h0;
   assign random_low_power = !rnd_any;

   // array writes, byte lane gated; cmd space targets command register instead
   always_ff @(posedge sys_clk) begin
      if (rnd_write && rnd_array && lane_en[0]) begin
         mem[random_addr][`DPSB_LO_MSB:0] <= random_data_in[`DPSB_LO_MSB:0];
      end
      if (rnd_write && rnd_array && lane_en[1]) begin
         mem[random_addr][15:`DPSB_HI_LSB] <= random_data_in[15:`DPSB_HI_LSB];
      end
   end

   // command register; bit 12 is read-only status, held zero here
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_reg <= '0;
      end else if (rnd_write && rnd_cmd) begin
         if (lane_en[0]) begin
            cmd_reg[`DPSB_LO_MSB:0] <= random_data_in[`DPSB_LO_MSB:0];
         end
         if (lane_en[1]) begin
            cmd_reg[`DPSB_CMD_WR_W-1:`DPSB_HI_LSB] <= random_data_in[`DPSB_CMD_WR_W-1:`DPSB_HI_LSB];
         end
      end
   end

   // sequential side: select and gates registered, so power state follows clocked level
   wire logic seq_adv = seq_sel && seq_rd && !seq_ctl.pointer_advance_enable_n;
   wire logic [ADDR_W-1:0] next_pointer = seq_pointer + ADDR_W'(1);
   wire logic sel_now = !seq_ctl.sequential_port_select_n;
   wire logic rd_now = seq_ctl.sequential_read_write;
   wire logic adv_now = sel_now && rd_now && !seq_ctl.pointer_advance_enable_n;

   assign end1_addr = `DPSB_END1_RESET;
   assign end2_addr = `DPSB_END2_RESET;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_sel <= 1'b0;
         seq_rd <= 1'b0;
         seq_oe_n <= 1'b1;
         seq_pointer <= `DPSB_PTR_RESET;
         first_buffer_end_flag_n <= 1'b1;
         second_buffer_end_flag_n <= 1'b1;
      end else begin
         seq_sel <= sel_now;
         seq_rd <= rd_now;
         seq_oe_n <= seq_ctl.sequential_output_gate_n;
         if (adv_now) begin
            seq_pointer <= next_pointer;
            if (next_pointer == end1_addr) begin
               first_buffer_end_flag_n <= 1'b0;
            end
            if (next_pointer == end2_addr) begin
               second_buffer_end_flag_n <= 1'b0;
            end
         end
      end
   end

   // data from the array: registered so the word follows the clocked pointer
   always_ff @(posedge sys_clk) begin
      seq_word <= adv_now ? mem[next_pointer] : mem[seq_pointer];
   end

   assign seq_data_out = seq_word;
   assign seq_data_oe = seq_sel && seq_rd && !seq_oe_n;
   assign seq_low_power = !seq_sel;

   property p_flags_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      !adv_now |=> $stable(first_buffer_end_flag_n) && $stable(second_buffer_end_flag_n);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("end flag changed without advance");

   property p_ptr_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      !adv_now |=> $stable(seq_pointer);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved while held");

   property p_ptr_adv;
      @(posedge sys_clk) disable iff (!reset_n)
      adv_now |=> seq_pointer == $past(seq_pointer) + ADDR_W'(1);
   endproperty
   a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

   property p_flag1_set;
      @(posedge sys_clk) disable iff (!reset_n)
      adv_now && next_pointer == end1_addr |=> !first_buffer_end_flag_n;
   endproperty
   a_flag1_set: assert property (p_flag1_set) else $error("first end flag not set");

   property p_flag2_set;
      @(posedge sys_clk) disable iff (!reset_n)
      adv_now && next_pointer == end2_addr |=> !second_buffer_end_flag_n;
   endproperty
   a_flag2_set: assert property (p_flag2_set) else $error("second end flag not set");

   property p_sel_clocked;
      @(posedge sys_clk) disable iff (!reset_n)
      sel_now ##1 !sel_now |-> !seq_low_power;
   endproperty
   a_sel_clocked: assert property (p_sel_clocked) else $error("select acted before clocking");

   property p_seq_float;
      @(posedge sys_clk) disable iff (!reset_n)
      !sel_now || !rd_now || seq_ctl.sequential_output_gate_n |=> !seq_data_oe;
   endproperty
   a_seq_float: assert property (p_seq_float) else $error("sequential data driven with gate high");

   property p_rnd_deselect;
      @(posedge sys_clk) disable iff (!reset_n)
      random_ctl.port_select_n && random_ctl.command_space_select_n |-> random_data_oe == 2'h0 && random_low_power;
   endproperty
   a_rnd_deselect: assert property (p_rnd_deselect) else $error("random port not floated when deselected");

   property p_rnd_lanes;
      @(posedge sys_clk) disable iff (!reset_n)
      rnd_array && random_ctl.high_byte_lane_n && random_ctl.low_byte_lane_n |->
         random_data_oe == 2'h0 && !random_low_power;
   endproperty
   a_rnd_lanes: assert property (p_rnd_lanes) else $error("lanes high but data driven");

   property p_cmd_read;
      @(posedge sys_clk) disable iff (!reset_n)
      rnd_cmd && rnd_read |-> random_data_out[15:`DPSB_CMD_RD_W] == '0;
   endproperty
   a_cmd_read: assert property (p_cmd_read) else $error("command read upper bits not zero");

   property p_rnd_gate;
      @(posedge sys_clk) disable iff (!reset_n)
      rnd_any && random_ctl.random_read_write && random_ctl.random_output_gate_n |->
         random_data_oe == 2'h0 && !random_low_power;
   endproperty
   a_rnd_gate: assert property (p_rnd_gate) else $error("read data driven with output gate high");

   property p_lane_low;
      @(posedge sys_clk) disable iff (!reset_n)
      rnd_read && !random_ctl.low_byte_lane_n && random_ctl.high_byte_lane_n |-> random_data_oe == 2'h1;
   endproperty
   a_lane_low: assert property (p_lane_low) else $error("lower lane read drove upper byte");

   property p_lane_high;
      @(posedge sys_clk) disable iff (!reset_n)
      rnd_read && random_ctl.low_byte_lane_n && !random_ctl.high_byte_lane_n |-> random_data_oe == 2'h2;
   endproperty
   a_lane_high: assert property (p_lane_high) else $error("upper lane read drove lower byte");

   property p_cmd_write;
      @(posedge sys_clk) disable iff (!reset_n)
      rnd_cmd && !random_ctl.random_read_write && lane_en == 2'h3 |=>
         cmd_reg[`DPSB_CMD_WR_W-1:0] == $past(random_data_in[`DPSB_CMD_WR_W-1:0]);
   endproperty
   a_cmd_write: assert property (p_cmd_write) else $error("command write not stored");

   property p_flag2_only;
      @(posedge sys_clk) disable iff (!reset_n)
      adv_now && next_pointer == end2_addr && next_pointer != end1_addr |=> $stable(first_buffer_end_flag_n);
   endproperty
   a_flag2_only: assert property (p_flag2_only) else $error("first end flag moved at second end");
endmodule // dpsb_ports

// ===== dpsb_agent.sv
// streaming agent model on the sequential side of the buffer ports
module dpsb_agent (
   input wire logic [3:0] cmd,
   input wire logic [15:0] seq_data_out,
   input wire logic seq_data_oe,
   output dpsb_pkg::dpsb_seq_ctl_t seq_ctl,
   output logic [15:0] seq_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] last = 16'h0000;
   assign seq_ctl = dpsb_pkg::dpsb_seq_ctl_t'(cmd);
   always @(seq_data_out, seq_data_oe) if (seq_data_oe) last = seq_data_out;
   // floated bus shows the inverse of the last word, never a stale copy
   assign seq_bus = seq_data_oe ? seq_data_out : ~last;
endmodule // dpsb_agent

// ===== dpsb_ports_test.sv
// self-checking bench of the dual-port sequential buffer ports
module dpsb_ports_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [5:0] c_rd = 6'h18, c_wr = 6'h14, c_wrl = 6'h15, c_rdl = 6'h19, c_rdh = 6'h1a;
   localparam logic [5:0] c_off = 6'h30, c_gate = 6'h1c, c_noln = 6'h13, c_cwr = 6'h24, c_crd = 6'h2a;
   localparam logic [5:0] c_nowr = 6'h17, c_cwh = 6'h26;
   logic sys_clk, reset_n, seq_data_oe, seq_low_power, random_low_power;
   logic first_buffer_end_flag_n, second_buffer_end_flag_n;
   dpsb_pkg::dpsb_rand_ctl_t random_ctl;
   dpsb_pkg::dpsb_seq_ctl_t seq_ctl;
   logic [11:0] random_addr, seq_pointer, a, p;
   logic [15:0] random_data_in, random_data_out, seq_data_out, seq_bus, d, b, e;
   logic [1:0] random_data_oe;
   logic [3:0] cmd;
   int i, seed = 7121, bad_count = 0, check_count = 0;
   dpsb_ports dpsb_ports_inst (.sys_clk, .reset_n, .random_ctl, .random_addr, .random_data_in,
      .random_data_out, .random_data_oe, .random_low_power, .seq_ctl, .seq_data_out, .seq_data_oe,
      .seq_low_power, .first_buffer_end_flag_n, .second_buffer_end_flag_n, .seq_pointer);
   dpsb_agent dpsb_agent_inst (.cmd, .seq_data_out, .seq_data_oe, .seq_ctl, .seq_bus);
   always #5 sys_clk = ~sys_clk;
   function automatic logic [15:0] mrg(logic [15:0] o, logic [15:0] n, logic [1:0] ln);
      return {ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
   endfunction
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic rp(input logic [5:0] c, input logic [11:0] ad, input logic [15:0] dt);
      @(negedge sys_clk);
      random_ctl = c;
      random_addr = ad;
      random_data_in = dt;
      #1;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      sys_clk = 0;
      reset_n = 0;
      random_ctl = c_off;
      random_addr = '0;
      random_data_in = '0;
      cmd = 4'he;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) reset_n = 1;
      chk("pointer", 16'h0000, {4'h0, seq_pointer});
      chk("flags", 16'h0003, {14'h0, first_buffer_end_flag_n, second_buffer_end_flag_n});
      cmd = 4'h2;
      for (i = 0; i < 8; i++) begin
         a = 12'($random(seed));
         d = 16'($random(seed));
         b = 16'($random(seed));
         rp(c_wr, a, d);
         rp(c_wrl, a, b);
         rp(c_rd, a, '0);
         e = mrg(d, b, 2'b01);
         chk("word", e, random_data_out);
         chk("oe both", 16'h0003, {14'h0, random_data_oe});
         rp(c_rdl, a, '0);
         chk("oe low", 16'h0001, {14'h0, random_data_oe});
         rp(c_rdh, a, '0);
         chk("oe high", 16'h0002, {14'h0, random_data_oe});
         chk("high byte", {8'h0, e[15:8]}, {8'h0, random_data_out[15:8]});
      end
      // write with both lanes off must leave the word alone
      rp(c_nowr, a, ~e);
      rp(c_off, a, '0);
      chk("off", 16'h0001, {13'h0, random_data_oe, random_low_power});
      rp(c_gate, a, '0);
      chk("gate", 16'h0000, {13'h0, random_data_oe, random_low_power});
      rp(c_noln, a, '0);
      chk("no lane", 16'h0000, {13'h0, random_data_oe, random_low_power});
      rp(c_rd, a, '0);
      chk("no lane write", e, random_data_out);
      $display("random port test done");
      cmd = 4'he;
      rp(c_cwr, '0, d);
      rp(c_crd, '0, '0);
      chk("command", {4'h0, d[11:0]}, random_data_out);
      rp(c_cwh, '0, ~d);
      rp(c_crd, '0, '0);
      chk("command upper", {4'h0, ~d[11:8], d[7:0]}, random_data_out);
      rp(c_wr, 12'hfff, 16'h5a5a);
      rp(c_wr, 12'h000, 16'ha5a5);
      rp(c_off, '0, '0);
      chk("seq idle", 16'h0001, {15'h0, seq_low_power});
      cmd = 4'h6;
      #1 chk("seq unclocked", 16'h0001, {15'h0, seq_low_power});
      @(negedge sys_clk) p = seq_pointer;
      chk("seq clocked", 16'h0000, {15'h0, seq_low_power});
      @(negedge sys_clk) chk("hold", {4'h0, p}, {4'h0, seq_pointer});
      cmd = 4'h3;
      @(negedge sys_clk) chk("gated", {4'h0, p + 12'h001}, {4'h0, seq_pointer});
      chk("gated oe", 16'h0000, {15'h0, seq_data_oe});
      cmd = 4'h2;
      for (i = 0; i < 5000 && seq_pointer !== 12'hfff; i++) @(negedge sys_clk);
      if (i == 5000) begin
         bad_count++;
         finish_test();
      end
      chk("end one word", 16'h5a5a, seq_bus);
      chk("end one", 16'h0001, {14'h0, first_buffer_end_flag_n, second_buffer_end_flag_n});
      @(negedge sys_clk) chk("end two word", 16'ha5a5, seq_bus);
      chk("end two", 16'h0000, {14'h0, first_buffer_end_flag_n, second_buffer_end_flag_n});
      cmd = 4'h6;
      @(negedge sys_clk) chk("sticky", 16'h0000, {4'h0, seq_pointer});
      chk("sticky flags", 16'h0000, {14'h0, first_buffer_end_flag_n, second_buffer_end_flag_n});
      // reset mid-run, seen before any clock edge
      reset_n = 0;
      #1 chk("async reset", 16'h0003, {14'h0, first_buffer_end_flag_n, second_buffer_end_flag_n});
      @(negedge sys_clk) reset_n = 1;
      chk("reset select", 16'h0001, {15'h0, seq_low_power});
      $display("sequential port test done");
      finish_test();
   end
endmodule // dpsb_ports_test
